// ---- inc/i2c_slave_defs.svh ----
// Constants of the two-wire register access slave.
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH

// Seven-bit bus address that the slave answers to.
`define SLV_DEV_ADDR   7'h51
// Highest valid register pointer value.
`define SLV_REG_LAST   8'h2F
// Lowest register pointer value, taken on wrap.
`define SLV_REG_FIRST  8'h00
// Number of registers in the space.
`define SLV_REG_COUNT  48
// Data bits in one byte on the wire.
`define SLV_BYTE_BITS  4'h8
// Reset value of every register cell, of the shifter and of the write data byte.
`define SLV_RESET_BYTE 8'h00

`endif

// ---- inc/i2c_slave_pkg.sv ----
// Types shared by the two-wire register access slave.
`default_nettype none

package i2c_slave_pkg;

  // Protocol states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,  // Ignoring the bus until a START.
    ST_ADDR  = 7'h02,  // Receiving the address byte.
    ST_PTR   = 7'h04,  // Receiving the pointer byte.
    ST_WDATA = 7'h08,  // Receiving write data bytes.
    ST_SACK  = 7'h10,  // Slave drives the acknowledge.
    ST_TX    = 7'h20,  // Slave shifts out a read byte.
    ST_MACK  = 7'h40   // Master answers a read byte.
  } slv_state_t;

endpackage : i2c_slave_pkg

`default_nettype wire

// ---- inc/reg_port_if.sv ----
// Register port between the protocol engine and the register store.
`default_nettype none

interface reg_port_if;
  logic       wr_en;  // One-cycle write strobe.
  logic [7:0] addr;   // Register pointer.
  logic [7:0] wdata;  // Byte to store.
  logic [7:0] rdata;  // Byte stored at addr.

  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_port_if

`default_nettype wire

// ---- rtl/slv_reg_store.sv ----
// Byte-wide store for the 48-entry register space.
`include "i2c_slave_defs.svh"
`default_nettype none

module slv_reg_store
(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Register port.
  reg_port_if.mem   rp
);

  // Register cells.
  logic [7:0] cells_r [`SLV_REG_COUNT];

  // *************************************************************
  // Storage
  // *************************************************************

  // Cells clear at reset and take a byte on each enabled write strobe whose address is in range.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `SLV_REG_COUNT; i++)
        cells_r[i] <= `SLV_RESET_BYTE;
    end
    else if (clk_en && rp.wr_en && (rp.addr <= `SLV_REG_LAST))
    begin
      cells_r[rp.addr[5:0]] <= rp.wdata;
    end
  end

  // Read is asynchronous so a byte is ready the moment the pointer moves.
  // Out-of-range addresses read as zero rather than aliasing.
  assign rp.rdata = (rp.addr <= `SLV_REG_LAST) ? cells_r[rp.addr[5:0]] : `SLV_RESET_BYTE;

endmodule : slv_reg_store

`default_nettype wire

// ---- rtl/i2c_register_access_slave.sv ----
// Two-wire serial slave giving byte access to a 48-entry register space.
`include "i2c_slave_defs.svh"
`default_nettype none

module i2c_register_access_slave
(
  // Clock, enable and reset.
  input  wire logic clk_sys,
  input  wire logic clk_en,
  input  wire logic rst_n,
  // Serial clock from the master.
  input  wire logic scl_in,
  // Serial data, open drain.
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Backup supply indication.
  input  wire logic on_battery,
  // Write notification to the rest of the chip.
  output logic      wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  // *************************************************************
  // Declarations
  // *************************************************************

  reg_port_if rp ();

  logic [1:0] scl_sync_r;   // Serial clock synchroniser.
  logic [1:0] sda_sync_r;   // Serial data synchroniser.
  logic [1:0] bat_sync_r;   // Backup supply synchroniser.
  logic       scl_prev_r;   // Previous synchronised clock level.
  logic       sda_prev_r;   // Previous synchronised data level.
  logic       scl_s;        // Synchronised clock.
  logic       sda_s;        // Synchronised data.
  logic       bat_s;        // Synchronised backup indication.
  logic       scl_rise;     // Clock rising edge.
  logic       scl_fall;     // Clock falling edge.
  logic       start_det;    // START seen.
  logic       stop_det;     // STOP seen.

  i2c_slave_pkg::slv_state_t st_r;      // Protocol state.
  i2c_slave_pkg::slv_state_t rx_next_r; // Receive state after a slave ack.
  logic [3:0] bit_cnt_r;    // Bits moved in the current byte.
  logic [7:0] shift_r;      // Byte shift register.
  logic       read_r;       // Transfer direction is read.
  logic       bad_r;        // Pointer out of range, writes discarded.
  logic [7:0] ptr_r;        // Register pointer.
  logic       oe_r;         // Data line pulled low.
  logic       wr_r;         // Write strobe to the store.
  logic [7:0] wdata_r;      // Byte written.
  logic [7:0] waddr_r;      // Where it was written.
  logic       byte_done;    // Eighth bit sampled, clock now falling.

  // Next pointer with wrap to the first register.
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p >= `SLV_REG_LAST) ? `SLV_REG_FIRST : p + 8'h01;
  endfunction : ptr_inc

  // *************************************************************
  // Input synchronisers and edge detection
  // *************************************************************

  // Two stages per pin; only the second stage is read by logic.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      bat_sync_r <= 2'h0;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      bat_sync_r <= {bat_sync_r[0], on_battery};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign bat_s     = bat_sync_r[1];
  assign scl_rise  = scl_s && !scl_prev_r;
  assign scl_fall  = !scl_s && scl_prev_r;
  // Data edges count as conditions only while the clock stays high.
  assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
  assign stop_det  = scl_s && scl_prev_r && !sda_prev_r && sda_s;
  assign byte_done = scl_fall && (bit_cnt_r == `SLV_BYTE_BITS);

  // *************************************************************
  // Protocol engine
  // *************************************************************

  // One process owns the state, bit count, shifter and data line.
  // Bits are only sampled at the clock rise, so data changes in the
  // high phase are read as conditions, never as data.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= i2c_slave_pkg::ST_IDLE;
      rx_next_r <= i2c_slave_pkg::ST_PTR;
      bit_cnt_r <= 4'h0;
      shift_r   <= `SLV_RESET_BYTE;
      read_r    <= 1'b0;
      bad_r     <= 1'b0;
      oe_r      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (bat_s)
      begin
        // Backup supply: release the line and forget the transfer.
        st_r <= i2c_slave_pkg::ST_IDLE;
        oe_r <= 1'b0;
      end
      else if (start_det)
      begin
        // START or repeated START wins over any state.
        st_r      <= i2c_slave_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        bad_r     <= 1'b0;
        oe_r      <= 1'b0;
      end
      else if (stop_det)
      begin
        st_r <= i2c_slave_pkg::ST_IDLE;
        oe_r <= 1'b0;
      end
      else
      begin
        unique case (st_r)
          i2c_slave_pkg::ST_IDLE:
          begin
            // Foreign or finished transfer: wait for START.
            oe_r <= 1'b0;
          end
          i2c_slave_pkg::ST_ADDR,
          i2c_slave_pkg::ST_PTR,
          i2c_slave_pkg::ST_WDATA:
          begin
            if (scl_rise)
            begin
              // MSB first into the low end of a left shift.
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (byte_done)
            begin
              bit_cnt_r <= 4'h0;
              if (st_r == i2c_slave_pkg::ST_ADDR)
              begin
                if (shift_r[7:1] == `SLV_DEV_ADDR)
                begin
                  read_r    <= shift_r[0];
                  rx_next_r <= i2c_slave_pkg::ST_PTR;
                  st_r      <= i2c_slave_pkg::ST_SACK;
                  oe_r      <= 1'b1;
                end
                else
                begin
                  st_r <= i2c_slave_pkg::ST_IDLE;
                end
              end
              else
              begin
                // Pointer and data bytes are always acknowledged.
                if (st_r == i2c_slave_pkg::ST_PTR)
                  bad_r <= (shift_r > `SLV_REG_LAST);
                rx_next_r <= i2c_slave_pkg::ST_WDATA;
                st_r      <= i2c_slave_pkg::ST_SACK;
                oe_r      <= 1'b1;
              end
            end
          end
          i2c_slave_pkg::ST_SACK:
          begin
            // Low held through the whole acknowledge clock.
            if (scl_fall)
            begin
              if (read_r)
              begin
                // Read data goes out at once, from the pointer.
                shift_r <= rp.rdata;
                oe_r    <= !rp.rdata[7];
                st_r    <= i2c_slave_pkg::ST_TX;
              end
              else
              begin
                oe_r <= 1'b0;
                st_r <= rx_next_r;
              end
            end
          end
          i2c_slave_pkg::ST_TX:
          begin
            // Open drain: pull low for a 0, release for a 1.
            if (scl_fall)
            begin
              if (bit_cnt_r == 4'h7)
              begin
                bit_cnt_r <= 4'h0;
                oe_r      <= 1'b0;
                st_r      <= i2c_slave_pkg::ST_MACK;
              end
              else
              begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r   <= {shift_r[6:0], 1'b0};
                oe_r      <= !shift_r[6];
              end
            end
          end
          i2c_slave_pkg::ST_MACK:
          begin
            // Master acknowledge: next byte; not-acknowledge: go quiet.
            if (scl_rise)
              shift_r[0] <= sda_s;
            else if (scl_fall)
            begin
              if (!shift_r[0])
              begin
                shift_r <= rp.rdata;
                oe_r    <= !rp.rdata[7];
                st_r    <= i2c_slave_pkg::ST_TX;
              end
              else
              begin
                st_r <= i2c_slave_pkg::ST_IDLE;
              end
            end
          end
          default:
          begin
            st_r <= i2c_slave_pkg::ST_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // *************************************************************
  // Pointer and register writes
  // *************************************************************

  // The pointer survives between transfers so a read resumes where the
  // last access left it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_r   <= `SLV_REG_FIRST;
      wr_r    <= 1'b0;
      wdata_r <= `SLV_RESET_BYTE;
      waddr_r <= `SLV_REG_FIRST;
    end
    else if (clk_en)
    begin
      wr_r <= 1'b0;
      if (!bat_s && !start_det && !stop_det)
      begin
        if (byte_done && (st_r == i2c_slave_pkg::ST_PTR) && (shift_r <= `SLV_REG_LAST))
        begin
          ptr_r <= shift_r;
        end
        else if (byte_done && (st_r == i2c_slave_pkg::ST_WDATA) && !bad_r)
        begin
          wr_r    <= 1'b1;
          wdata_r <= shift_r;
          waddr_r <= ptr_r;
          ptr_r   <= ptr_inc(ptr_r);
        end
        else if ((st_r == i2c_slave_pkg::ST_TX) && scl_fall && (bit_cnt_r == 4'h7))
        begin
          ptr_r <= ptr_inc(ptr_r);
        end
      end
    end
  end

  assign rp.wr_en = wr_r;
  assign rp.addr  = wr_r ? waddr_r : ptr_r;
  assign rp.wdata = wdata_r;

  // Register store.
  slv_reg_store u_store
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .rp      (rp.mem)
  );

  assign sda_out   = 1'b0;
  assign sda_oe    = oe_r;
  assign wr_strobe = wr_r;
  assign wr_addr   = waddr_r;
  assign wr_data   = wdata_r;

  // *************************************************************
  // Checks
  // *************************************************************

  start_to_addr_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && start_det && !bat_s) |=> (st_r == i2c_slave_pkg::ST_ADDR) && !sda_oe)
    else $error("START did not open an address phase");

  stop_to_idle_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && stop_det && !start_det) |=> (st_r == i2c_slave_pkg::ST_IDLE))
    else $error("STOP did not return to idle");

  ack_drives_low_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == i2c_slave_pkg::ST_SACK) |-> sda_oe)
    else $error("Acknowledge not driven low");

  foreign_quiet_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && byte_done && st_r == i2c_slave_pkg::ST_ADDR && !bat_s && !start_det
     && !stop_det && shift_r[7:1] != `SLV_DEV_ADDR)
    |=> (st_r == i2c_slave_pkg::ST_IDLE) && !sda_oe)
    else $error("Foreign address was answered");

  battery_silent_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && bat_s) |=> !sda_oe && !wr_strobe)
    else $error("Bus answered on backup supply");

  ptr_wrap_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_strobe && wr_addr == `SLV_REG_LAST) |-> (ptr_r == `SLV_REG_FIRST))
    else $error("Pointer did not wrap after last register");

  bad_ptr_nowrite_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && bad_r) |=> !wr_strobe)
    else $error("Write made after out-of-range pointer");

  tx_bit_drive_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == i2c_slave_pkg::ST_TX) |-> (sda_oe == !shift_r[7]))
    else $error("Read bit does not match shifter MSB");

  read_inc_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && st_r == i2c_slave_pkg::ST_TX && scl_fall && bit_cnt_r == 4'h7
     && !bat_s && !start_det && !stop_det)
    |=> (ptr_r == ptr_inc($past(ptr_r))))
    else $error("Pointer did not advance after read byte");

endmodule : i2c_register_access_slave

`default_nettype wire

// ---- tb/i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the serial clock and pulls the data line.
`default_nettype none

module i2c_master_model
(
  // Resolved data line level.
  input  wire logic sda_wire,
  // Master drive.
  output logic      scl_out,
  output logic      m_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // **********************************************************************
  // Timing knobs
  // **********************************************************************
  // A quarter of the 80 ns serial period.
  int unsigned qtr_ns = 20;
  // Part of the low phase before the data changes; raising it makes a slow master.
  int unsigned low_ns = 20;

  // The clock stands high and the data line is released outside frames.
  initial
  begin
    scl_out = 1'b1;
    m_oe    = 1'b0;
  end

  // **********************************************************************
  // Bus conditions
  // **********************************************************************
  // START or repeated START, entered idle or with the clock low.
  task automatic start_cond;
  begin
    #(qtr_ns);
    m_oe = 1'b0;
    #(qtr_ns);
    scl_out = 1'b1;
    #(2 * qtr_ns);
    m_oe = 1'b1;
    #(2 * qtr_ns);
    scl_out = 1'b0;
  end
  endtask : start_cond

  // STOP leaves both lines high, so the clock stands still afterwards.
  task automatic stop_cond;
  begin
    #(qtr_ns);
    m_oe = 1'b1;
    #(qtr_ns);
    scl_out = 1'b1;
    #(2 * qtr_ns);
    m_oe = 1'b0;
    #(4 * qtr_ns);
  end
  endtask : stop_cond

  // **********************************************************************
  // Bit and byte transfer
  // **********************************************************************
  // Data changes only while the clock is low and stands for the high phase.
  task automatic bit_xfer(input logic b, output logic seen);
  begin
    #(low_ns);
    m_oe = ~b;
    #(qtr_ns);
    scl_out = 1'b1;
    #(qtr_ns);
    seen = sda_wire;
    #(qtr_ns);
    scl_out = 1'b0;
  end
  endtask : bit_xfer

  // Eight bits MSB first, then the answer clock; send FF to receive.
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
    int i;
  begin
    for (i = 7; i >= 0; i--)
      bit_xfer(tx[i], rx[i]);
    bit_xfer(ack_in, ack_out);
  end
  endtask : xfer_byte
endmodule : i2c_master_model

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the two-wire register access slave.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // **********************************************************************
  // Signals
  // **********************************************************************
  logic        clk_sys;     // 200 MHz system clock.
  logic        rst_n;       // Active low reset.
  logic        clk_en;      // Held on; freezing is not exercised.
  logic        on_battery;  // Backup supply indication.
  logic        scl_w;       // Serial clock from the master.
  logic        sda_w;       // Resolved data line with pull-up.
  logic        m_oe;        // Master pulls data low.
  logic        sda_oe;      // Slave pulls data low.
  logic        sda_o;       // Slave data value, used only while sda_oe is high.
  logic        wr_strobe;   // Write pulse from the slave.
  logic [7:0]  wr_addr;     // Index of that write.
  logic [7:0]  wr_data;     // Byte of that write.
  logic [15:0] wr_q[$];     // Writes seen, as index and byte.
  int          n_errors;    // Mismatches.
  int          check_count; // Comparisons.
  int          cycles;      // Cycles run, for the hang limit.

  // Open drain: the line is low while the master pulls it or the slave drives its value.
  // Taking the slave's data value into the wire means a wrong sda_out shows up at once.
  assign sda_w = ~(m_oe | (sda_oe & ~sda_o));

  i2c_register_access_slave dut_u
  (
    .clk_sys    (clk_sys),
    .clk_en     (clk_en),
    .rst_n      (rst_n),
    .scl_in     (scl_w),
    .sda_in     (sda_w),
    .sda_out    (sda_o),
    .sda_oe     (sda_oe),
    .on_battery (on_battery),
    .wr_strobe  (wr_strobe),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data)
  );

  i2c_master_model master_u
  (
    .sda_wire (sda_w),
    .scl_out  (scl_w),
    .m_oe     (m_oe)
  );

  // **********************************************************************
  // Clock, monitor and hang limit
  // **********************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Every write pulse is logged so that a missing or extra one shows.
  always @(posedge clk_sys)
  begin
    if (wr_strobe === 1'b1)
      wr_q.push_back({wr_addr, wr_data});
  end

  // The tests need about 6700 cycles; the ceiling leaves wide margin.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // **********************************************************************
  // Shared tasks
  // **********************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask : check

  // Sends a byte with the line released in the answer clock.
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
  begin
    master_u.xfer_byte(b, 1'b1, rx, ack);
    check("answer bit", 16'(ack), 16'(exp_ack));
    // The slave must leave the line alone while the master sends its bits.
    check("line echo", 16'(rx), 16'(b));
  end
  endtask : send

  // Receives a byte and answers it with the given bit.
  task automatic recv(input logic [7:0] exp, input logic mack);
    logic [7:0] rx;
    logic       ack;
  begin
    master_u.xfer_byte(8'hFF, mack, rx, ack);
    check("read byte", 16'(rx), 16'(exp));
    // The slave must have released the line for the master's answer clock.
    check("master answer", 16'(ack), 16'(mack));
  end
  endtask : recv

  task automatic exp_wr(input logic [15:0] e);
  begin
    check("write pulse", (wr_q.size() != 0) ? wr_q.pop_front() : 16'hXXXX, e);
  end
  endtask : exp_wr

  task automatic no_wr;
  begin
    check("write count", 16'(wr_q.size()), 16'h0000);
  end
  endtask : no_wr

  task automatic end_sim;
  begin
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask : end_sim

  // **********************************************************************
  // Scenarios
  // **********************************************************************
  // After reset the pointer is 00 and cells read 00; leaves pointer at 02.
  task automatic t_reset_read;
  begin
    check("idle drive", 16'(sda_oe), 16'h0000);
    master_u.start_cond();
    send(8'hA3, 1'b0);
    recv(8'h00, 1'b0);
    recv(8'h00, 1'b1);
    master_u.stop_cond();
    $display("test reset_read done");
  end
  endtask : t_reset_read

  // Writes across the top of the space; the pointer wraps to 00.
  task automatic t_write_wrap;
  begin
    master_u.start_cond();
    send(8'hA2, 1'b0);
    send(8'h2E, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    master_u.stop_cond();
    exp_wr(16'h2E11);
    exp_wr(16'h2F22);
    exp_wr(16'h0033);
    no_wr();
    $display("test write_wrap done");
  end
  endtask : t_write_wrap

  // Pointer-only write, repeated START, read across the wrap, slow master.
  task automatic t_read_wrap;
  begin
    master_u.low_ns = 200;
    master_u.start_cond();
    send(8'hA2, 1'b0);
    send(8'h2E, 1'b0);
    master_u.start_cond();
    send(8'hA3, 1'b0);
    recv(8'h11, 1'b0);
    recv(8'h22, 1'b0);
    recv(8'h33, 1'b1);
    master_u.stop_cond();
    master_u.low_ns = 20;
    no_wr();
    $display("test read_wrap done");
  end
  endtask : t_read_wrap

  // Pointer 30 is out of range: all acknowledged, nothing stored, pointer kept at 01.
  task automatic t_bad_ptr;
  begin
    master_u.start_cond();
    send(8'hA2, 1'b0);
    send(8'h30, 1'b0);
    send(8'h55, 1'b0);
    master_u.stop_cond();
    no_wr();
    master_u.start_cond();
    send(8'hA3, 1'b0);
    recv(8'h00, 1'b1);
    master_u.stop_cond();
    $display("test bad_ptr done");
  end
  endtask : t_bad_ptr

  // Foreign addresses are left unanswered, and so are the bytes after them.
  task automatic t_foreign;
  begin
    master_u.start_cond();
    send(8'hA4, 1'b1);
    send(8'h00, 1'b1);
    master_u.start_cond();
    send(8'hA1, 1'b1);
    master_u.stop_cond();
    no_wr();
    $display("test foreign done");
  end
  endtask : t_foreign

  // On the backup supply nothing answers and nothing is written.
  task automatic t_battery;
  begin
    @(posedge clk_sys);
    #1 on_battery = 1'b1;
    repeat (8) @(posedge clk_sys);
    // Keep the master's edges off the sampling edge of the system clock.
    #1;
    master_u.start_cond();
    send(8'hA2, 1'b1);
    send(8'h01, 1'b1);
    send(8'h77, 1'b1);
    master_u.stop_cond();
    no_wr();
    @(posedge clk_sys);
    #1 on_battery = 1'b0;
    repeat (8) @(posedge clk_sys);
    // Keep the master's edges off the sampling edge of the system clock.
    #1;
    master_u.start_cond();
    send(8'hA2, 1'b0);
    send(8'h01, 1'b0);
    master_u.start_cond();
    send(8'hA3, 1'b0);
    recv(8'h00, 1'b1);
    master_u.stop_cond();
    $display("test battery done");
  end
  endtask : t_battery

  // **********************************************************************
  // Main sequence
  // **********************************************************************
  initial
  begin
    rst_n       = 1'b0;
    clk_en      = 1'b1;
    on_battery  = 1'b0;
    n_errors    = 0;
    check_count = 0;
    cycles      = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    // All master timing is in whole multiples of the clock period, so this
    // offset keeps every pin change just after a rising edge.
    #1;
    t_reset_read();
    t_write_wrap();
    t_read_wrap();
    t_bad_ptr();
    t_foreign();
    t_battery();
    end_sim();
  end
endmodule : testbench

`default_nettype wire
